// ---- logic/nvac_pkg.sv ----
package nvac_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADDR_DATA_LOW = 3'h0;
  localparam logic [2:0] ADDR_DATA_HIGH = 3'h1;
  localparam logic [2:0] ADDR_ADDR_LOW = 3'h2;
  localparam logic [2:0] ADDR_ADDR_HIGH = 3'h3;
  localparam logic [2:0] ADDR_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_UNLOCK = 3'h5;
  // Control register bit positions
  localparam int BIT_READ = 0;
  localparam int BIT_COMMIT = 1;
  localparam int BIT_ARM = 2;
  localparam int BIT_ERR = 3;
  localparam int BIT_DONE = 4;
  localparam int BIT_DONE_IE = 5;
  localparam int BIT_SELECT = 7;
  // Unlock key bytes
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Widths and masks
  localparam int PADDR_W = 13;
  localparam int PDATA_W = 14;
  localparam logic [5:0] DATA_HIGH_MASK = 6'h3f;
  localparam logic [4:0] ADDR_HIGH_MASK = 5'h1f;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Program read takes two instruction cycles
  localparam logic [1:0] PREAD_CYCLES = 2'h2;

  typedef enum {NVAC_IDLE, NVAC_PREAD, NVAC_DWRITE, NVAC_PWRITE} nvac_state_t;

  typedef struct packed {
    nvac_state_t st;
    logic [7:0] data_low;
    logic [5:0] data_high;
    logic [7:0] addr_low;
    logic [4:0] addr_high;
    logic select;
    logic arm;
    logic rd;
    logic wr;
    logic err;
    logic done;
    logic done_ie;
    logic [1:0] unlock;
    logic [1:0] cnt;
    logic mem_req;
  } nvac_regs_t;

  typedef struct packed {
    logic req;
    logic write;
    logic prog;
    logic [PADDR_W-1:0] addr;
    logic [PDATA_W-1:0] wdata;
  } nvac_mem_req_t;
endpackage

// ---- logic/nvac_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - A write starts one erase-then-program pass on a byte or word.
// - No register path exists to request a bulk erase.
// - Program writes pass any 14-bit value unchanged.
// - Write length is set by the array's self-timed done signal only.
// - Data EEPROM writes never stall the processor.
// - Program writes stall execution and block program fetch until done.
// - Clock runs on; interrupts queue while stalled, taken after next instruction.
// - All access goes through the six data, address, control, unlock registers.
// - Low address gives EEPROM byte address; low data holds the byte.
// - Small variant keeps address top bit; 0x80 never aliases 0x00.
// - Large variant decodes all eight low address bits.
// - High:low address forms 13-bit word address; data forms 14-bit word.
// - Program addresses never wrap; out-of-range is passed, not folded.
// - Unlock port stores nothing; writes only step the unlock sequence.
// - Select clear targets data EEPROM, set targets program memory.
// - Read strobe starts read, ignores zero writes, self-clears at end.
// - EEPROM read byte lands in low data the next cycle.
// - Program read uses two cycles, then loads the full word.
// - Data registers hold their value until new read or firmware write.
// - Commit only accepted when arm was set by an earlier write.
// - Commit only accepted right after 55h then AAh to the unlock port.
// - Clearing arm mid-write does not abort the write.
// - Flash write lock clear blocks every program memory write.
module nvac_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic flash_lock_cfg,
  input wire logic irq_pending,
  output logic cpu_stall,
  output logic irq_hold,
  output logic nv_irq,
  output nvac_pkg::nvac_mem_req_t mem_req,
  input wire logic [7:0] ee_rdata,
  input wire logic [13:0] prog_rdata,
  input wire logic write_done
);
  nvac_pkg::nvac_regs_t r_q;
  nvac_pkg::nvac_regs_t r_d;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [7:0] ctl_val;
  logic wr_ctl;
  logic key_ok;

  always_comb
  begin
    ctl_val = nvac_pkg::ZERO8;
    ctl_val[nvac_pkg::BIT_READ] = r_q.rd;
    ctl_val[nvac_pkg::BIT_COMMIT] = r_q.wr;
    ctl_val[nvac_pkg::BIT_ARM] = r_q.arm;
    ctl_val[nvac_pkg::BIT_ERR] = r_q.err;
    ctl_val[nvac_pkg::BIT_DONE] = r_q.done;
    ctl_val[nvac_pkg::BIT_DONE_IE] = r_q.done_ie;
    ctl_val[nvac_pkg::BIT_SELECT] = r_q.select;
  end

  always_comb
  begin
    r_d = r_q;
    r_d.mem_req = 1'b0;
    wr_ctl = reg_wr && (reg_addr == nvac_pkg::ADDR_CONTROL);
    // Key must be the very last write before commit
    key_ok = (r_q.unlock == 2'h2);
    // Data register writes are taken; reads later overwrite them
    if (reg_wr && reg_addr == nvac_pkg::ADDR_DATA_LOW)
    begin
      r_d.data_low = reg_wdata;
    end
    else if (reg_wr && reg_addr == nvac_pkg::ADDR_DATA_HIGH)
    begin
      r_d.data_high = reg_wdata[5:0] & nvac_pkg::DATA_HIGH_MASK;
    end
    else if (reg_wr && reg_addr == nvac_pkg::ADDR_ADDR_LOW)
    begin
      r_d.addr_low = reg_wdata;
    end
    else if (reg_wr && reg_addr == nvac_pkg::ADDR_ADDR_HIGH)
    begin
      r_d.addr_high = reg_wdata[4:0] & nvac_pkg::ADDR_HIGH_MASK;
    end
    // Unlock sequence: any other register write breaks it
    if (reg_wr && reg_addr == nvac_pkg::ADDR_UNLOCK)
    begin
      if (reg_wdata == nvac_pkg::KEY_FIRST)
      begin
        r_d.unlock = 2'h1;
      end
      else if (reg_wdata == nvac_pkg::KEY_SECOND && r_q.unlock == 2'h1)
      begin
        r_d.unlock = 2'h2;
      end
      else
      begin
        r_d.unlock = 2'h0;
      end
    end
    else if (reg_wr)
    begin
      r_d.unlock = 2'h0;
    end
    if (wr_ctl)
    begin
      // Bulk erase has no control bit at all
      r_d.arm = reg_wdata[nvac_pkg::BIT_ARM];
      r_d.done_ie = reg_wdata[nvac_pkg::BIT_DONE_IE];
      if (!reg_wdata[nvac_pkg::BIT_DONE])
      begin
        r_d.done = 1'b0;
      end
      if (!reg_wdata[nvac_pkg::BIT_ERR])
      begin
        r_d.err = 1'b0;
      end
      if (r_q.st == nvac_pkg::NVAC_IDLE)
      begin
        r_d.select = reg_wdata[nvac_pkg::BIT_SELECT];
      end
    end
    case (r_q.st)
      nvac_pkg::NVAC_IDLE:
      begin
        if (wr_ctl && reg_wdata[nvac_pkg::BIT_COMMIT] && r_q.arm && key_ok)
        begin
          if (reg_wdata[nvac_pkg::BIT_SELECT] && !flash_lock_cfg)
          begin
            r_d.err = 1'b1;
          end
          else
          begin
            r_d.wr = 1'b1;
            r_d.mem_req = 1'b1;
            r_d.st = reg_wdata[nvac_pkg::BIT_SELECT] ?
              nvac_pkg::NVAC_PWRITE : nvac_pkg::NVAC_DWRITE;
          end
        end
        else if (wr_ctl && reg_wdata[nvac_pkg::BIT_READ])
        begin
          r_d.rd = 1'b1;
          r_d.mem_req = 1'b1;
          if (reg_wdata[nvac_pkg::BIT_SELECT])
          begin
            r_d.cnt = 2'h1;
            r_d.st = nvac_pkg::NVAC_PREAD;
          end
          else
          begin
            r_d.st = nvac_pkg::NVAC_DWRITE;
          end
        end
      end
      nvac_pkg::NVAC_PREAD:
      begin
        if (r_q.cnt == nvac_pkg::PREAD_CYCLES)
        begin
          r_d.data_low = prog_rdata[7:0];
          r_d.data_high = prog_rdata[13:8];
          r_d.rd = 1'b0;
          r_d.st = nvac_pkg::NVAC_IDLE;
        end
        else
        begin
          r_d.cnt = r_q.cnt + 2'h1;
        end
      end
      nvac_pkg::NVAC_DWRITE:
      begin
        if (r_q.rd)
        begin
          // EEPROM read answer arrives one cycle after the strobe
          r_d.data_low = ee_rdata;
          r_d.rd = 1'b0;
          r_d.st = nvac_pkg::NVAC_IDLE;
        end
        else if (write_done)
        begin
          r_d.wr = 1'b0;
          r_d.done = 1'b1;
          r_d.st = nvac_pkg::NVAC_IDLE;
        end
      end
      nvac_pkg::NVAC_PWRITE:
      begin
        // Arm is ignored here so the write cannot be cut short
        if (write_done)
        begin
          r_d.wr = 1'b0;
          r_d.done = 1'b1;
          r_d.st = nvac_pkg::NVAC_IDLE;
        end
      end
      default:
      begin
        r_d.st = nvac_pkg::NVAC_IDLE;
      end
    endcase
  end

  always_comb
  begin
    rdata_d = nvac_pkg::ZERO8;
    if (reg_rd)
    begin
      if (reg_addr == nvac_pkg::ADDR_DATA_LOW)
      begin
        rdata_d = r_q.data_low;
      end
      else if (reg_addr == nvac_pkg::ADDR_DATA_HIGH)
      begin
        rdata_d = {2'h0, r_q.data_high};
      end
      else if (reg_addr == nvac_pkg::ADDR_ADDR_LOW)
      begin
        rdata_d = r_q.addr_low;
      end
      else if (reg_addr == nvac_pkg::ADDR_ADDR_HIGH)
      begin
        rdata_d = {3'h0, r_q.addr_high};
      end
      else if (reg_addr == nvac_pkg::ADDR_CONTROL)
      begin
        rdata_d = ctl_val;
      end
      else
      begin
        rdata_d = nvac_pkg::ZERO8;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_q <= '0;
      rdata_q <= nvac_pkg::ZERO8;
    end
    else
    begin
      r_q <= r_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  // Whole address passed on; the array decides range, no folding here
  assign mem_req.req = r_q.mem_req;
  assign mem_req.write = r_q.wr;
  assign mem_req.prog = r_q.select;
  assign mem_req.addr = {r_q.addr_high, r_q.addr_low};
  assign mem_req.wdata = {r_q.data_high, r_q.data_low};
  assign cpu_stall = (r_q.st == nvac_pkg::NVAC_PWRITE);
  // Core holds interrupt vectoring while stalled; events keep pending
  assign irq_hold = cpu_stall && irq_pending;
  assign nv_irq = r_q.done && r_q.done_ie;
endmodule
`default_nettype wire

// ---- verif/nvac_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvac_mem_model #(
  parameter int DLY = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire nvac_pkg::nvac_mem_req_t mem_req,
  output logic [7:0] ee_rdata,
  output logic [13:0] prog_rdata,
  output logic write_done
);
  logic [3:0] cnt_q;
  logic rd;
  logic [7:0] eev;
  assign rd = mem_req.req && !mem_req.write;
  assign eev = mem_req.addr[7:0] ^ 8'h5a;
  // Unselected data shows the inverse so a stale sample never matches
  assign ee_rdata = rd ? eev : ~eev;
  assign write_done = (cnt_q == 4'h1);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 4'h0;
      prog_rdata <= 14'h0000;
    end
    else
    begin
      prog_rdata <= rd ? {mem_req.addr, 1'b1} : ~prog_rdata;
      if (mem_req.req && mem_req.write)
        cnt_q <= 4'(DLY);
      else if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- verif/nvac_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvac_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic flash_lock_cfg,
  input wire logic irq_pending,
  input wire logic cpu_stall,
  input wire logic irq_hold,
  input wire logic nv_irq,
  input wire nvac_pkg::nvac_mem_req_t mem_req,
  input wire logic write_done
);
  logic wc;
  logic wk;
  logic pw;
  assign wc = reg_wr && reg_addr == nvac_pkg::ADDR_CONTROL;
  assign wk = reg_wr && reg_addr == nvac_pkg::ADDR_UNLOCK;
  assign pw = mem_req.req && mem_req.write;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_hold_follow: assert property (irq_hold == (cpu_stall && irq_pending))
    else $error("irq hold wrong");
  a_stall_start: assert property ($rose(cpu_stall) |-> pw && mem_req.prog)
    else $error("stall without program write");
  a_ee_nostall: assert property (pw && !mem_req.prog |-> !cpu_stall[*3])
    else $error("stall on data write");
  a_stall_end: assert property ($fell(cpu_stall) |-> $past(write_done))
    else $error("stall ended without done");
  a_lock_gate: assert property (pw && mem_req.prog |-> $past(flash_lock_cfg))
    else $error("program write while locked");
  a_unlock_seq: assert property (pw |-> $past(wc && reg_wdata[1]) &&
    $past(wk && reg_wdata == nvac_pkg::KEY_SECOND, 2) &&
    $past(wk && reg_wdata == nvac_pkg::KEY_FIRST, 3))
    else $error("write without unlock sequence");
  a_read_src: assert property (mem_req.req && !mem_req.write |->
    $past(wc && reg_wdata[0]) && mem_req.prog == $past(reg_wdata[7]))
    else $error("read request without strobe");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  cover property (pw && mem_req.prog);
  cover property (pw && !mem_req.prog);
  cover property (mem_req.req && !mem_req.write && mem_req.prog);
endmodule
bind nvac_top nvac_sva i_nvac_sva (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_lock_cfg(flash_lock_cfg),
  .irq_pending(irq_pending), .cpu_stall(cpu_stall), .irq_hold(irq_hold),
  .nv_irq(nv_irq), .mem_req(mem_req), .write_done(write_done));
`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic s; logic [12:0] a; logic [13:0] d;} nvac_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic flash_lock_cfg = 1'b1;
  logic irq_pending = 1'b0;
  logic [7:0] reg_rdata, ee_rdata;
  logic [13:0] prog_rdata;
  logic cpu_stall, irq_hold, nv_irq, write_done;
  nvac_pkg::nvac_mem_req_t mem_req;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  nvac_row_t rows [5] = '{'{0, 13'h0000, 14'h005a}, '{0, 13'h0080, 14'h00da},
    '{0, 13'h00ff, 14'h00a5}, '{1, 13'h1fff, 14'h3fff},
    '{1, 13'h0a55, 14'h14ab}};
  nvac_top i_nvac_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_lock_cfg(flash_lock_cfg),
    .irq_pending(irq_pending), .cpu_stall(cpu_stall), .irq_hold(irq_hold),
    .nv_irq(nv_irq), .mem_req(mem_req), .ee_rdata(ee_rdata),
    .prog_rdata(prog_rdata), .write_done(write_done));
  nvac_mem_model i_nvac_mem_model (.clk(clk), .rst_n(rst_n),
    .mem_req(mem_req), .ee_rdata(ee_rdata), .prog_rdata(prog_rdata),
    .write_done(write_done));
  always #4 clk = ~clk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    // Whole run needs well under a thousand cycles
    if (cyc == 4000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, r, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    idle(1);
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  task automatic key(input logic [7:0] k1, k2, c);
    wr(nvac_pkg::ADDR_UNLOCK, k1);
    wr(nvac_pkg::ADDR_UNLOCK, k2);
    wr(nvac_pkg::ADDR_CONTROL, c);
    idle(1);
  endtask
  task automatic waitfor(input logic irq);
    int n;
    for (n = 0; n < 100; n++)
    begin
      @(negedge clk);
      if ((irq ? nv_irq : mem_req.req) === 1'b1)
        break;
    end
    chk(n < 100, 1);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc(nvac_pkg::ADDR_CONTROL, 8'h00);
    foreach (rows[i])
    begin
      wr(nvac_pkg::ADDR_ADDR_LOW, rows[i].a[7:0]);
      wr(nvac_pkg::ADDR_ADDR_HIGH, {3'h0, rows[i].a[12:8]});
      wr(nvac_pkg::ADDR_CONTROL, {rows[i].s, 7'h01});
      idle(3);
      rdc(nvac_pkg::ADDR_DATA_LOW, rows[i].d[7:0]);
      if (rows[i].s)
        rdc(nvac_pkg::ADDR_DATA_HIGH, {2'h0, rows[i].d[13:8]});
    end
    rdc(nvac_pkg::ADDR_DATA_LOW, 8'hab);
    $display("test reads done");
    wr(nvac_pkg::ADDR_ADDR_HIGH, 8'h1f);
    wr(nvac_pkg::ADDR_ADDR_LOW, 8'hff);
    wr(nvac_pkg::ADDR_DATA_HIGH, 8'h3f);
    wr(nvac_pkg::ADDR_DATA_LOW, 8'ha5);
    wr(nvac_pkg::ADDR_CONTROL, 8'h84);
    irq_pending <= 1'b1;
    key(8'h55, 8'haa, 8'ha6);
    waitfor(1'b0);
    chk(mem_req.wdata, 14'h3fa5);
    chk(mem_req.addr, 13'h1fff);
    chk(mem_req.write, 1'b1);
    chk({cpu_stall, irq_hold}, 2'h3);
    wr(nvac_pkg::ADDR_CONTROL, 8'ha0);
    idle(1);
    waitfor(1'b1);
    chk(cpu_stall, 1'b0);
    rdc(nvac_pkg::ADDR_CONTROL, 8'hb0);
    $display("test program write done");
    wr(nvac_pkg::ADDR_CONTROL, 8'h80);
    key(8'h55, 8'haa, 8'h86);
    rdc(nvac_pkg::ADDR_CONTROL, 8'h84);
    key(8'haa, 8'h55, 8'h86);
    flash_lock_cfg <= 1'b0;
    rdc(nvac_pkg::ADDR_CONTROL, 8'h84);
    key(8'h55, 8'haa, 8'h86);
    rdc(nvac_pkg::ADDR_CONTROL, 8'h8c);
    $display("test refusals done");
    wr(nvac_pkg::ADDR_CONTROL, 8'h04);
    key(8'h55, 8'haa, 8'h26);
    waitfor(1'b0);
    chk({cpu_stall, mem_req.prog}, 2'h0);
    waitfor(1'b1);
    rdc(nvac_pkg::ADDR_CONTROL, 8'h34);
    rdc(nvac_pkg::ADDR_UNLOCK, 8'h00);
    rdc(3'h6, 8'h00);
    $display("test data write done");
    idle(1);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    rdc(nvac_pkg::ADDR_CONTROL, 8'h00);
    rdc(nvac_pkg::ADDR_DATA_LOW, 8'h00);
    chk({cpu_stall, nv_irq}, 2'h0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
